// ---- rtl/crh_handler.sv ----
// CAN register message handler: decodes requests, keeps registers, replies
//Behaviour
//- Every data frame carries exactly two data bytes, length code two.
//- First byte bits 4..0 select the register; second byte is data.
//- Outgoing first byte bits 6..5 give bus mode; value 3 never sent.
//- Outgoing bit 7 flags error passive since the last sent frame.
//- Upper three bits of outgoing first byte hold mode and error.
//- Unsolicited status on init done, enabled pin edge, wake-up.
//- Status frame uses pointer 0x0F with pin 7..0 levels.
//- Pointers 0x00, 0x05, 0x08..0x0F are read-only for all writers.
//- Other defined pointers writable by CAN and by the loader.
//- Read-only request samples pins or analog input, then replies.
//- Write stores byte, applies it, replies with new content.
//- Even identifier transmits, next odd identifier receives.
//- In loader mode a global receive identifier is also accepted.
//- Frame is addressed only when identifier bit 0 is set.
//- Addressed remote frame gets a status frame reply.
//- Requests arriving while one is in progress are ignored.
`default_nettype none
module crh_handler
	import crh_pkg::*;
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      reset_n_i,
	input  wire crh_pkg::crh_frame_t       rx_frame_i,
	output crh_pkg::crh_frame_t            tx_frame_o,
	input  wire logic                      tx_ready_i,
	input  wire logic [crh_pkg::CRH_ID_W-1:0] node_id_i,
	input  wire logic                      loader_mode_i,
	input  wire logic [crh_pkg::CRH_ID_W-1:0] global_id_i,
	input  wire logic                      loader_wr_i,
	input  wire logic [4:0]                loader_ptr_i,
	input  wire logic [7:0]                loader_data_i,
	input  wire logic                      init_done_i,
	input  wire logic                      wake_i,
	input  wire logic [1:0]                bus_mode_field_i,
	input  wire logic                      error_passive_i,
	input  wire logic [7:0]                pin_low_i,
	input  wire logic [5:0]                pin_high_i,
	output logic                           adc_req_o,
	output logic [2:0]                     adc_channel_o,
	input  wire logic                      adc_done_i,
	input  wire logic [7:0]                adc_data_i,
	output crh_pkg::crh_cfg_t              cfg_o,
	output logic                           busy_o
);
	import crh_pkg::*;

	typedef struct packed {
		crh_state_t              state;
		logic [4:0]              ptr;
		logic                    status_pend;
		logic                    error_passive_flag;
		logic [CRH_NREG-1:0][7:0] regs;
		crh_frame_t              tx;
	} crh_state_all_t;

	crh_state_all_t s;
	crh_state_all_t next_s;

	logic [7:0] low_level;
	logic [7:0] low_rise;
	logic [7:0] low_fall;
	logic [5:0] high_level;
	logic       addressed;
	logic       edge_event;
	logic [4:0] rp_w;

	crh_pin_sync #(.W(8)) u_low_sync (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (pin_low_i),
		.level_o   (low_level),
		.rise_o    (low_rise),
		.fall_o    (low_fall)
	);

	crh_pin_sync #(.W(6)) u_high_sync (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (pin_high_i),
		.level_o   (high_level),
		.rise_o    (),
		.fall_o    ()
	);

	function automatic logic is_writable(input logic [4:0] p);
		is_writable = (p >= CRH_PTR_RISE_SEL && p <= CRH_PTR_LOW_DIR) ||
			p == CRH_PTR_HIGH_OUT || p == CRH_PTR_HIGH_DIR ||
			(p >= CRH_PTR_DAC_FIRST && p <= CRH_PTR_DAC_LAST) ||
			p == CRH_PTR_DAC_CTL || p == CRH_PTR_CMP_CTL ||
			p == CRH_PTR_CONFIG;
	endfunction

	function automatic logic is_adc(input logic [4:0] p);
		is_adc = p >= CRH_PTR_ADC_FIRST && p <= CRH_PTR_ADC_LAST;
	endfunction

	function automatic logic [CRH_NREG-1:0][7:0] reset_regs();
		logic [CRH_NREG-1:0][7:0] r;
		r = '0;
		for (int i = 0; i < CRH_NREG; i++) begin
			r[i] = CRH_RST_OTHER;
		end
		r[CRH_PTR_LOW_OUT]  = CRH_RST_OUT;
		r[CRH_PTR_HIGH_OUT] = CRH_RST_OUT;
		return r;
	endfunction

	// Own receive id is the odd partner of the even transmit id
	assign addressed = rx_frame_i.valid && rx_frame_i.id[0] &&
		((rx_frame_i.id[CRH_ID_W-1:1] == node_id_i[CRH_ID_W-1:1]) ||
		(loader_mode_i && rx_frame_i.id == global_id_i));
	assign rp_w = rx_frame_i.data0[4:0];

	assign edge_event = |((low_rise & s.regs[CRH_PTR_RISE_SEL]) |
		(low_fall & s.regs[CRH_PTR_FALL_SEL]));

	always_comb begin
		logic [7:0] b0_flags;
		logic [4:0] rp;
		logic       load_frame;
		logic [4:0] tx_ptr;
		logic [7:0] tx_data;
		b0_flags   = '0;
		rp         = rx_frame_i.data0[4:0];
		load_frame = 1'b0;
		tx_ptr     = '0;
		tx_data    = '0;
		next_s     = s;

		// Loader writes only reach writable pointers
		if (loader_wr_i && is_writable(loader_ptr_i)) begin
			next_s.regs[loader_ptr_i] = loader_data_i;
		end

		case (s.state)
		CRH_IDLE: begin
			// Non-idle states never look at rx, so extra requests drop
			if (addressed && rx_frame_i.remote) begin
				next_s.regs[CRH_PTR_LOW_IN] = low_level;
				tx_ptr     = CRH_PTR_STATUS;
				tx_data    = low_level;
				load_frame = 1'b1;
			end else if (addressed && rx_frame_i.dlc == CRH_FRAME_DLC) begin
				next_s.ptr = rp;
				if (rp == CRH_PTR_LOW_IN || rp == CRH_PTR_STATUS) begin
					next_s.regs[CRH_PTR_LOW_IN] = low_level;
					tx_ptr     = rp;
					tx_data    = low_level;
					load_frame = 1'b1;
				end else if (rp == CRH_PTR_HIGH_IN) begin
					next_s.regs[CRH_PTR_HIGH_IN] = {2'h0, high_level};
					tx_ptr     = rp;
					tx_data    = {2'h0, high_level};
					load_frame = 1'b1;
				end else if (is_adc(rp)) begin
					next_s.state = CRH_ADC;
				end else if (is_writable(rp)) begin
					next_s.regs[rp] = rx_frame_i.data1;
					tx_ptr     = rp;
					tx_data    = rx_frame_i.data1;
					load_frame = 1'b1;
				end
				// Undefined pointers fall through; only ptr is stored, no reply
			end else if (s.status_pend) begin
				next_s.status_pend = 1'b0;
				tx_ptr     = CRH_PTR_STATUS;
				tx_data    = low_level;
				load_frame = 1'b1;
			end
		end
		CRH_ADC: begin
			if (adc_done_i) begin
				next_s.regs[s.ptr] = adc_data_i;
				tx_ptr     = s.ptr;
				tx_data    = adc_data_i;
				load_frame = 1'b1;
			end
		end
		CRH_SEND: begin
			if (tx_ready_i) begin
				next_s.tx.valid        = 1'b0;
				next_s.error_passive_flag = 1'b0;
				next_s.state           = CRH_IDLE;
			end
		end
		default: begin
			next_s.state = CRH_IDLE;
		end
		endcase

		if (load_frame) begin
			b0_flags[CRH_B0_ERR] = s.error_passive_flag | error_passive_i;
			b0_flags[CRH_B0_MODE_H:CRH_B0_MODE_L] =
				(bus_mode_field_i == CRH_MODE_BAD) ? 2'h0 : bus_mode_field_i;
			next_s.tx.valid  = 1'b1;
			next_s.tx.id     = {node_id_i[CRH_ID_W-1:1], 1'b0};
			next_s.tx.remote = 1'b0;
			next_s.tx.dlc    = CRH_FRAME_DLC;
			next_s.tx.data0  = b0_flags | {3'h0, tx_ptr};
			next_s.tx.data1  = tx_data;
			next_s.state     = CRH_SEND;
		end

		// Setting wins over the clear done when a frame is sent
		if (error_passive_i) begin
			next_s.error_passive_flag = 1'b1;
		end
		if (init_done_i || wake_i || edge_event) begin
			next_s.status_pend = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			s.state              <= CRH_IDLE;
			s.ptr                <= '0;
			s.status_pend        <= 1'b0;
			s.error_passive_flag <= 1'b0;
			s.regs               <= reset_regs();
			s.tx                 <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tx_frame_o    = s.tx;
	assign adc_req_o     = (s.state == CRH_ADC);
	assign adc_channel_o = 3'(s.ptr - CRH_PTR_ADC_FIRST);
	assign busy_o        = (s.state != CRH_IDLE);

	assign cfg_o.rise_sel = s.regs[CRH_PTR_RISE_SEL];
	assign cfg_o.fall_sel = s.regs[CRH_PTR_FALL_SEL];
	assign cfg_o.low_out  = s.regs[CRH_PTR_LOW_OUT];
	assign cfg_o.low_dir  = s.regs[CRH_PTR_LOW_DIR];
	assign cfg_o.high_out = s.regs[CRH_PTR_HIGH_OUT];
	assign cfg_o.high_dir = s.regs[CRH_PTR_HIGH_DIR];
	assign cfg_o.dac_ctl  = s.regs[CRH_PTR_DAC_CTL];
	assign cfg_o.cmp_ctl  = s.regs[CRH_PTR_CMP_CTL];
	assign cfg_o.config_r = s.regs[CRH_PTR_CONFIG];
	for (genvar d = 0; d < 4; d++) begin : g_dac
		assign cfg_o.dac[d] = s.regs[CRH_PTR_DAC_FIRST + 5'(d)];
	end

	property p_dlc_two;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		tx_frame_o.valid |-> tx_frame_o.dlc == CRH_FRAME_DLC;
	endproperty
	a_dlc_two: assert property (p_dlc_two)
		else $error("transmit frame length is not two");

	property p_mode_legal;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		tx_frame_o.valid |-> tx_frame_o.data0[6:5] != CRH_MODE_BAD;
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("bus mode field sent as three");

	property p_err_flag;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		$rose(tx_frame_o.valid) |-> tx_frame_o.data0[7] ==
			$past(s.error_passive_flag | error_passive_i);
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("error passive not flagged in frame");

	property p_even_tx_id;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		tx_frame_o.valid |-> !tx_frame_o.id[0] &&
			tx_frame_o.id[CRH_ID_W-1:1] == node_id_i[CRH_ID_W-1:1];
	endproperty
	a_even_tx_id: assert property (p_even_tx_id)
		else $error("transmit identifier not the even one");

	property p_write_reply;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_IDLE && addressed && !rx_frame_i.remote &&
			rx_frame_i.dlc == CRH_FRAME_DLC && is_writable(rp_w) |=>
			tx_frame_o.valid && tx_frame_o.data1 == $past(rx_frame_i.data1)
			&& tx_frame_o.data0[4:0] == $past(rp_w)
			&& s.regs[$past(rp_w)] == $past(rx_frame_i.data1);
	endproperty
	a_write_reply: assert property (p_write_reply)
		else $error("write not stored or not echoed");

	property p_remote_status;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_IDLE && addressed && rx_frame_i.remote |=>
			tx_frame_o.valid && tx_frame_o.data0[4:0] == CRH_PTR_STATUS &&
			tx_frame_o.data1 == $past(low_level);
	endproperty
	a_remote_status: assert property (p_remote_status)
		else $error("remote frame not answered with pin status");

	property p_busy_ignore;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_SEND && !tx_ready_i |=> $stable(tx_frame_o) ##0
			s.state == CRH_SEND;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("pending reply disturbed while busy");

	property p_readonly;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		loader_wr_i && !is_writable(loader_ptr_i) && !rx_frame_i.valid &&
			s.state != CRH_ADC |=> $stable(s.regs);
	endproperty
	a_readonly: assert property (p_readonly)
		else $error("read-only register altered by loader");

	property p_drop_undefined;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_IDLE && addressed && !rx_frame_i.remote &&
			!is_writable(rp_w) && !is_adc(rp_w) && rp_w != CRH_PTR_LOW_IN &&
			rp_w != CRH_PTR_HIGH_IN && rp_w != CRH_PTR_STATUS &&
			!s.status_pend |=> !tx_frame_o.valid;
	endproperty
	a_drop_undefined: assert property (p_drop_undefined)
		else $error("undefined pointer produced a reply");

	property p_not_addressed;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_IDLE && rx_frame_i.valid && !rx_frame_i.id[0] &&
			!s.status_pend |=> !tx_frame_o.valid;
	endproperty
	a_not_addressed: assert property (p_not_addressed)
		else $error("frame with direction bit clear was answered");

	property p_adc_reply;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_ADC && adc_done_i |=> tx_frame_o.valid &&
			tx_frame_o.data1 == $past(adc_data_i) &&
			tx_frame_o.data0[4:0] == $past(s.ptr) &&
			s.regs[$past(s.ptr)] == $past(adc_data_i);
	endproperty
	a_adc_reply: assert property (p_adc_reply)
		else $error("analog read not stored or not replied");

	property p_status_frame;
		@(posedge sys_clk_i) disable iff (!reset_n_i)
		s.state == CRH_IDLE && s.status_pend && !addressed |=>
			tx_frame_o.valid && tx_frame_o.data0[4:0] == CRH_PTR_STATUS &&
			tx_frame_o.data1 == $past(low_level);
	endproperty
	a_status_frame: assert property (p_status_frame)
		else $error("pending status frame not sent with pin levels");
endmodule
`default_nettype wire

// ---- rtl/crh_pin_sync.sv ----
// Two-stage pin synchroniser with per-bit edge detection
`default_nettype none
module crh_pin_sync #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	typedef struct packed {
		logic [2:0]   fill;
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} crh_sync_state_t;

	crh_sync_state_t s;
	crh_sync_state_t next_s;

	always_comb begin
		next_s      = s;
		next_s.fill = {s.fill[1:0], 1'b1};
		next_s.meta = pin_i;
		next_s.sync = s.meta;
		next_s.prev = s.sync;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level_o = s.sync;

	// Edges held off until prev is filled, else a high pin looks like a rise
	for (genvar i = 0; i < W; i++) begin : g_edge
		assign rise_o[i] = s.fill[2] & s.sync[i] & ~s.prev[i];
		assign fall_o[i] = s.fill[2] & ~s.sync[i] & s.prev[i];
	end
endmodule
`default_nettype wire

// ---- rtl/crh_pkg.sv ----
// Shared constants and types of the CAN register message handler
`default_nettype none
package crh_pkg;
	localparam int CRH_ID_W    = 11;
	localparam int CRH_PTR_W   = 5;
	localparam int CRH_NREG    = 32;
	localparam logic [3:0] CRH_FRAME_DLC = 4'h2;

	// Register pointers
	localparam logic [4:0] CRH_PTR_LOW_IN   = 5'h00;
	localparam logic [4:0] CRH_PTR_RISE_SEL = 5'h01;
	localparam logic [4:0] CRH_PTR_FALL_SEL = 5'h02;
	localparam logic [4:0] CRH_PTR_LOW_OUT  = 5'h03;
	localparam logic [4:0] CRH_PTR_LOW_DIR  = 5'h04;
	localparam logic [4:0] CRH_PTR_HIGH_IN  = 5'h05;
	localparam logic [4:0] CRH_PTR_HIGH_OUT = 5'h06;
	localparam logic [4:0] CRH_PTR_HIGH_DIR = 5'h07;
	localparam logic [4:0] CRH_PTR_ADC_FIRST = 5'h08;
	localparam logic [4:0] CRH_PTR_ADC_LAST  = 5'h0e;
	localparam logic [4:0] CRH_PTR_STATUS    = 5'h0f;
	localparam logic [4:0] CRH_PTR_DAC_FIRST = 5'h10;
	localparam logic [4:0] CRH_PTR_DAC_LAST  = 5'h13;
	localparam logic [4:0] CRH_PTR_DAC_CTL   = 5'h1c;
	localparam logic [4:0] CRH_PTR_CMP_CTL   = 5'h1e;
	localparam logic [4:0] CRH_PTR_CONFIG    = 5'h1f;

	// Reset values of the register block
	localparam logic [7:0] CRH_RST_OUT   = 8'hff;
	localparam logic [7:0] CRH_RST_OTHER = 8'h00;

	// First data byte layout
	localparam int CRH_B0_ERR    = 7;
	localparam int CRH_B0_MODE_H = 6;
	localparam int CRH_B0_MODE_L = 5;
	localparam logic [1:0] CRH_MODE_BAD = 2'h3;

	typedef enum logic [2:0] {
		CRH_IDLE = 3'b001,
		CRH_ADC  = 3'b010,
		CRH_SEND = 3'b100
	} crh_state_t;

	typedef struct packed {
		logic                valid;
		logic [CRH_ID_W-1:0] id;
		logic                remote;
		logic [3:0]          dlc;
		logic [7:0]          data0;
		logic [7:0]          data1;
	} crh_frame_t;

	typedef struct packed {
		logic [7:0]      rise_sel;
		logic [7:0]      fall_sel;
		logic [7:0]      low_out;
		logic [7:0]      low_dir;
		logic [7:0]      high_out;
		logic [7:0]      high_dir;
		logic [3:0][7:0] dac;
		logic [7:0]      dac_ctl;
		logic [7:0]      cmp_ctl;
		logic [7:0]      config_r;
	} crh_cfg_t;
endpackage
`default_nettype wire

// ---- verification/crh_can_master.sv ----
// CAN master model: sends requests and takes replies after a set stall
`default_nettype none
module crh_can_master
	import crh_pkg::*;
(
	input  wire logic                sys_clk_i,
	input  wire logic [3:0]          stall_i,
	input  wire crh_pkg::crh_frame_t tx_frame_i,
	output logic                     tx_ready_o,
	output crh_pkg::crh_frame_t      rx_frame_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] wait_cnt;

	initial begin
		tx_ready_o = 1'b0;
		wait_cnt = 4'h0;
		rx_frame_o = '0;
	end

	// Reply taken after stall_i cycles so slow masters are covered too
	always @(posedge sys_clk_i) begin
		if (tx_ready_o || !tx_frame_i.valid) begin
			tx_ready_o <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (wait_cnt == stall_i) begin
			tx_ready_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end

	// Fields other than remote are inverted after the pulse since they are not held
	task automatic send(input logic [10:0] id, input logic remote,
		input logic [3:0] dlc, input logic [7:0] d0, input logic [7:0] d1);
		@(posedge sys_clk_i);
		#1;
		rx_frame_o = '{1'b1, id, remote, dlc, d0, d1};
		@(posedge sys_clk_i);
		#1;
		rx_frame_o = '{1'b0, ~id, remote, ~dlc, ~d0, ~d1};
	endtask
endmodule
`default_nettype wire

// ---- verification/test_crh_handler.sv ----
// Self-checking bench of the CAN register message handler
`default_nettype none
module test_crh_handler
	import crh_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [1:0] mode;
		logic [4:0] ptr;
		logic [7:0] wr;
		logic [7:0] rd;
	} crh_row_t;
	localparam crh_row_t ROWS [11] = '{
		'{2'h1, 5'h00, 8'h55, 8'hc0},
		'{2'h0, 5'h04, 8'hf0, 8'hf0},
		'{2'h2, 5'h05, 8'h00, 8'h2a},
		'{2'h3, 5'h0f, 8'h00, 8'hc0},
		'{2'h1, 5'h06, 8'h3c, 8'h3c},
		'{2'h1, 5'h07, 8'h0f, 8'h0f},
		'{2'h1, 5'h10, 8'h11, 8'h11},
		'{2'h1, 5'h13, 8'h44, 8'h44},
		'{2'h1, 5'h1c, 8'ha5, 8'ha5},
		'{2'h1, 5'h1f, 8'h5a, 8'h5a},
		'{2'h1, 5'h01, 8'h01, 8'h01}
	};
	logic       sys_clk_i;
	logic       reset_n_i;
	crh_frame_t rx_frame;
	crh_frame_t tx_frame;
	logic       tx_ready;
	logic [10:0] node_id;
	logic [10:0] global_id;
	logic       loader_mode;
	logic       loader_wr;
	logic [4:0] loader_ptr;
	logic [7:0] loader_data;
	logic       init_done;
	logic       wake;
	logic [1:0] bus_mode;
	logic       error_passive;
	logic [7:0] pin_low;
	logic [5:0] pin_high;
	logic       adc_req;
	logic [2:0] adc_ch;
	logic       adc_done;
	logic [7:0] adc_data;
	crh_cfg_t   cfg;
	logic       busy;
	logic [3:0] stall;
	int         fail_count;
	int         checks;

	always #2.5 sys_clk_i = ~sys_clk_i;

	crh_handler u_crh_handler (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.rx_frame_i(rx_frame), .tx_frame_o(tx_frame), .tx_ready_i(tx_ready),
		.node_id_i(node_id), .loader_mode_i(loader_mode),
		.global_id_i(global_id), .loader_wr_i(loader_wr),
		.loader_ptr_i(loader_ptr), .loader_data_i(loader_data),
		.init_done_i(init_done), .wake_i(wake), .bus_mode_field_i(bus_mode),
		.error_passive_i(error_passive), .pin_low_i(pin_low),
		.pin_high_i(pin_high), .adc_req_o(adc_req), .adc_channel_o(adc_ch),
		.adc_done_i(adc_done), .adc_data_i(adc_data), .cfg_o(cfg),
		.busy_o(busy));

	crh_can_master u_crh_can_master (.sys_clk_i(sys_clk_i), .stall_i(stall),
		.tx_frame_i(tx_frame), .tx_ready_o(tx_ready), .rx_frame_o(rx_frame));

	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic cmp_v(input string what, input logic [103:0] exp, got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_frame(input string what, input crh_frame_t exp);
		checks++;
		if (tx_frame !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, tx_frame);
		end
	endtask

	task automatic step(inout int n, input string what);
		tick(1);
		n++;
		if (n > 40) begin
			fail_count++;
			$display("BAD %s expected done seen stuck", what);
			end_of_test();
		end
	endtask

	// Waits for the reply, then for the handshake to finish
	task automatic expect_reply(input logic [7:0] d0, d1, input string what);
		int n;
		n = 0;
		while (tx_frame.valid !== 1'b1) step(n, what);
		cmp_frame(what, '{1'b1, 11'h400, 1'b0, CRH_FRAME_DLC, d0, d1});
		while (busy !== 1'b0 || tx_frame.valid !== 1'b0) step(n, what);
	endtask

	task automatic expect_none(input string what);
		logic seen;
		seen = 1'b0;
		repeat (10) begin
			tick(1);
			if (tx_frame.valid !== 1'b0) seen = 1'b1;
		end
		cmp_v(what, 104'(0), 104'(seen));
	endtask

	initial begin
		sys_clk_i = 1'b0;
		reset_n_i = 1'b0;
		node_id = 11'h400;
		global_id = 11'h555;
		{loader_mode, loader_wr, loader_ptr, loader_data} = '0;
		{init_done, wake, error_passive, adc_done, adc_data} = '0;
		bus_mode = 2'h1;
		pin_low = 8'hc0;
		pin_high = 6'h2a;
		stall = 4'h0;
		fail_count = 0;
		checks = 0;
		tick(4);
		cmp_v("reset cfg", {16'h0, 8'hff, 8'h0, 8'hff, 64'h0}, cfg);
		reset_n_i = 1'b1;
		tick(3);
		init_done = 1'b1;
		tick(1);
		init_done = 1'b0;
		expect_reply(8'h2f, 8'hc0, "init status");
		for (int i = 0; i < 11; i++) begin
			stall = 4'(i % 4);
			bus_mode = ROWS[i].mode;
			u_crh_can_master.send(11'h401, 1'b0, CRH_FRAME_DLC,
				{3'h0, ROWS[i].ptr}, ROWS[i].wr);
			expect_reply({1'b0, (ROWS[i].mode == 2'h3) ? 2'h0 : ROWS[i].mode,
				ROWS[i].ptr}, ROWS[i].rd, "row");
		end
		error_passive = 1'b1;
		tick(1);
		error_passive = 1'b0;
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h1f, 8'h5a);
		expect_reply(8'hbf, 8'h5a, "error set");
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h1f, 8'h5a);
		expect_reply(8'h3f, 8'h5a, "error clear");
		u_crh_can_master.send(11'h400, 1'b0, 4'h2, 8'h04, 8'h00);
		expect_none("even id");
		u_crh_can_master.send(11'h401, 1'b0, 4'h3, 8'h04, 8'h00);
		expect_none("dlc 3");
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h14, 8'h00);
		expect_none("gap ptr");
		u_crh_can_master.send(11'h555, 1'b0, 4'h2, 8'h04, 8'h00);
		expect_none("global off");
		u_crh_can_master.send(11'h401, 1'b1, 4'h0, 8'h00, 8'h00);
		expect_reply(8'h2f, 8'hc0, "remote");
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h09, 8'h00);
		tick(1);
		cmp_v("adc req", 104'(5'h13), 104'({adc_req, adc_ch, busy}));
		// Arrives mid conversion, so it must vanish
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h03, 8'h12);
		adc_data = 8'h77;
		adc_done = 1'b1;
		tick(1);
		adc_done = 1'b0;
		expect_reply(8'h29, 8'h77, "adc read");
		expect_none("busy drop");
		cmp_v("low_out kept", 104'(8'hff), 104'(cfg.low_out));
		pin_low = 8'hc1;
		expect_reply(8'h2f, 8'hc1, "edge status");
		pin_low = 8'hc0;
		expect_none("edge off");
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		expect_reply(8'h2f, 8'hc0, "wake status");
		loader_mode = 1'b1;
		u_crh_can_master.send(11'h555, 1'b0, 4'h2, 8'h1e, 8'h3c);
		expect_reply(8'h3e, 8'h3c, "global id");
		loader_wr = 1'b1;
		loader_ptr = 5'h02;
		loader_data = 8'h81;
		tick(1);
		loader_ptr = 5'h05;
		loader_data = 8'h99;
		tick(1);
		loader_wr = 1'b0;
		cmp_v("cfg", {40'h0181fff03c, 32'h0f440000, 32'h11a53c5a}, cfg);
		u_crh_can_master.send(11'h401, 1'b0, 4'h2, 8'h05, 8'h00);
		expect_reply(8'h25, 8'h2a, "loader ro");
		end_of_test();
	end
endmodule
`default_nettype wire
